/* File: include/ocp_pkg.sv */
package ocp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CYCLE_MS = 5;
  localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
  localparam int unsigned STAMP_MS = CYCLE_MS;
  // ----------------------------------------------------------------
  // Register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_ISET = 6'h04;
  localparam logic [5:0] OFF_HLIM = 6'h08;
  localparam logic [5:0] OFF_TDEL = 6'h0c;
  localparam logic [5:0] OFF_TREL = 6'h10;
  localparam logic [5:0] OFF_STAT = 6'h14;
  localparam logic [5:0] OFF_EXPT = 6'h18;
  localparam logic [5:0] OFF_REMT = 6'h1c;
  localparam logic [5:0] OFF_RATIO = 6'h20;
  localparam int CTRL_INRUSH = 0;
  localparam int CTRL_FORCE = 1;
  localparam int CTRL_SWBLK = 2;
  localparam int CTRL_MAG = 3;
  localparam int CTRL_MODE = 5;
  localparam int CTRL_IDMT = 8;
  localparam int STAT_PHASE = 4;
  localparam int STAT_MODE = 8;
  localparam int STAT_OUT = 12;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ISET_RST = 16'h0078;
  localparam logic [15:0] HLIM_RST = 16'h0001;
  localparam logic [19:0] TDEL_RST = 20'h00014;
  localparam logic [19:0] TREL_RST = 20'h00000;
  localparam logic [1:0] MAG_RMS = 2'h1;
  localparam logic [1:0] MAG_TRMS = 2'h2;
  localparam logic [1:0] MAG_PP = 2'h3;
  localparam logic [2:0] MODE_ON = 3'h1;
  localparam logic [2:0] MODE_BLK = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  localparam logic [2:0] MODE_TBLK = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [3:0] PH_SINGLE = 4'h1;
  localparam logic [3:0] PH_TRIP1 = 4'h3;
  localparam logic [3:0] PH_AB = 4'h7;
  localparam logic [3:0] PH_BC = 4'h8;
  localparam logic [3:0] PH_CA = 4'h9;
  localparam logic [3:0] PH_ABC = 4'ha;
  localparam logic [3:0] PH_TRIP2 = 4'h4;
  localparam int unsigned PCT = 100;
  localparam int unsigned HYST_PCT = 97;
  localparam int unsigned HARM_SCALE = 10000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_TRIP = 2'b11,
    ST_BLOCKED = 2'b10
  } ocp_state_type;
  typedef struct packed {
    logic [15:0] rms;
    logic [15:0] trms;
    logic [15:0] pp;
  } ocp_mag_type;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } ocp_out_type;
  typedef struct packed {
    logic valid;
    logic [31:0] stamp;
    logic [2:0] fault;
    logic [2:0][15:0] cur;
  } ocp_evt_type;
endpackage : ocp_pkg

/* File: rtl/ocp_stage.sv */
`timescale 1ns/100ps
// Function
// - Any phase above shared threshold picks up.
// - Pick-up releases below 97 percent threshold.
// - Threshold in 0.01 nominal steps, default 1.20.
// - Blocking sampled at each processing cycle start.
// - Blocking comes from dedicated matrix input.
// - Pick-up without blocking gives start, timing.
// - Pick-up with blocking gives blocked only.
// - Blocking during start drops start, release timing.
// - Blocking raises stamped event and display note.
// - Optional second-harmonic inrush restraint, default off.
// - Inrush limit in 0.01 percent steps.
// - Forcing mode lets software drive blocking.
// - Condition code normal, start, trip, blocked.
// - Per-phase condition code zero to fourteen.
// - Expected operating time, 5 ms resolution.
// - Remaining time to trip counts down.
// - Highest current over threshold, 0.01 resolution.
// - Node behaviour code one to five.
// - Definite and inverse time delays supported.
// - Magnitude selectable RMS, TRMS, peak-to-peak.
module ocp_stage #(
  parameter int unsigned CYCLE_CLKS = ocp_pkg::CYCLE_CLKS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ocp_pkg::ocp_mag_type [2:0] measured_magnitude,
  input wire logic [2:0][15:0] harm2In,
  input wire logic [2:0][15:0] fundIn,
  input wire logic blockIn,
  output ocp_pkg::ocp_out_type stageOut,
  output ocp_pkg::ocp_evt_type blockEvt,
  output logic hmiNote,
  output logic cycleTick
);
  // ----------------------------------------------------------------
  // Processing cycle divider
  // ----------------------------------------------------------------
  logic [31:0] divQ;
  logic tickQ;
  logic [31:0] stampQ;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      divQ <= 32'h0;
      tickQ <= 1'b0;
    end
    else
    begin
      tickQ <= (divQ == 32'(CYCLE_CLKS - 1));
      divQ <= (divQ == 32'(CYCLE_CLKS - 1)) ? 32'h0 : divQ + 32'h1;
    end
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      stampQ <= 32'h0;
    else if (tickQ)
      stampQ <= stampQ + 32'(ocp_pkg::STAMP_MS);
  assign cycleTick = tickQ;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [8:0] ctrlQ;
  logic [15:0] isetQ;
  logic [15:0] hlimQ;
  logic [19:0] tdelQ;
  logic [19:0] trelQ;
  logic ackQ;
  logic [31:0] rdQ;
  logic [31:0] statW;
  logic [19:0] expQ;
  logic [19:0] remQ;
  logic [15:0] ratioQ;
  logic [1:0] condQ;
  logic [3:0] phCodeQ;
  logic [2:0] modeW;
  logic wrEn;
  assign modeW = ctrlQ[ocp_pkg::CTRL_MODE +: 3];
  assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
  assign wrEn = avs_write & ~ackQ;
  assign statW = {16'h0, 1'b0, stageOut, 1'b0, modeW, phCodeQ, 2'h0, condQ};
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      ackQ <= 1'b0;
    else
      ackQ <= (avs_read | avs_write) & ~ackQ;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      ctrlQ <= {1'b0, ocp_pkg::MODE_ON, ocp_pkg::MAG_RMS, 3'h0};
      isetQ <= ocp_pkg::ISET_RST;
      hlimQ <= ocp_pkg::HLIM_RST;
      tdelQ <= ocp_pkg::TDEL_RST;
      trelQ <= ocp_pkg::TREL_RST;
    end
    else if (wrEn)
      case (avs_address)
        ocp_pkg::OFF_CTRL: ctrlQ <= avs_writedata[8:0];
        ocp_pkg::OFF_ISET: isetQ <= avs_writedata[15:0];
        ocp_pkg::OFF_HLIM: hlimQ <= avs_writedata[15:0];
        ocp_pkg::OFF_TDEL: tdelQ <= avs_writedata[19:0];
        ocp_pkg::OFF_TREL: trelQ <= avs_writedata[19:0];
        default: ;
      endcase
  // Read data is latched in the first bus cycle and shown with the ack.
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      rdQ <= 32'h0;
    else if (avs_read & ~ackQ)
      case (avs_address)
        ocp_pkg::OFF_CTRL: rdQ <= {23'h0, ctrlQ};
        ocp_pkg::OFF_ISET: rdQ <= {16'h0, isetQ};
        ocp_pkg::OFF_HLIM: rdQ <= {16'h0, hlimQ};
        ocp_pkg::OFF_TDEL: rdQ <= {12'h0, tdelQ};
        ocp_pkg::OFF_TREL: rdQ <= {12'h0, trelQ};
        ocp_pkg::OFF_STAT: rdQ <= statW;
        ocp_pkg::OFF_EXPT: rdQ <= {12'h0, expQ};
        ocp_pkg::OFF_REMT: rdQ <= {12'h0, remQ};
        ocp_pkg::OFF_RATIO: rdQ <= {16'h0, ratioQ};
        default: rdQ <= 32'h0;
      endcase
  assign avs_readdata = rdQ;
  // ----------------------------------------------------------------
  // Blocking input synchroniser
  // ----------------------------------------------------------------
  logic [2:0] blkSyncQ;
  logic blkLvlQ;
  logic blkNow;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      blkSyncQ <= 3'h0;
      blkLvlQ <= 1'b0;
    end
    else
    begin
      blkSyncQ <= {blkSyncQ[1:0], blockIn};
      if (blkSyncQ[1] == blkSyncQ[2])
        blkLvlQ <= blkSyncQ[2];
    end
  // ----------------------------------------------------------------
  // Magnitude select, pick-up and inrush
  // ----------------------------------------------------------------
  logic [2:0][15:0] magW;
  logic [2:0] pickQ;
  logic [2:0] pickD;
  logic [2:0] harmW;
  logic [15:0] maxW;
  logic pickAnyD;
  logic modeOn;
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    always_comb
      case (ctrlQ[ocp_pkg::CTRL_MAG +: 2])
        ocp_pkg::MAG_TRMS: magW[p] = measured_magnitude[p].trms;
        ocp_pkg::MAG_PP: magW[p] = measured_magnitude[p].pp;
        default: magW[p] = measured_magnitude[p].rms;
      endcase
    always_comb
      if (magW[p] > isetQ)
        pickD[p] = 1'b1;
      else if (32'(magW[p]) * 32'(ocp_pkg::PCT) < 32'(isetQ) * 32'(ocp_pkg::HYST_PCT))
        pickD[p] = 1'b0;
      else
        pickD[p] = pickQ[p];
    assign harmW[p] = 32'(harm2In[p]) * 32'(ocp_pkg::HARM_SCALE) >=
                      32'(hlimQ) * 32'(fundIn[p]) && fundIn[p] != 16'h0;
  end
  assign pickAnyD = |pickD;
  assign maxW = (magW[0] > magW[1]) ? ((magW[0] > magW[2]) ? magW[0] : magW[2]) :
                ((magW[1] > magW[2]) ? magW[1] : magW[2]);
  assign modeOn = modeW != ocp_pkg::MODE_OFF;
  // Software switch replaces the matrix input only while forcing is on.
  assign blkNow = (ctrlQ[ocp_pkg::CTRL_FORCE] ? ctrlQ[ocp_pkg::CTRL_SWBLK] : blkLvlQ)
                  | (ctrlQ[ocp_pkg::CTRL_INRUSH] & |harmW)
                  | modeW == ocp_pkg::MODE_BLK | modeW == ocp_pkg::MODE_TBLK;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      pickQ <= 3'h0;
    else if (tickQ)
      pickQ <= modeOn ? pickD : 3'h0;
  // ----------------------------------------------------------------
  // Ratio and operating time
  // ----------------------------------------------------------------
  logic [15:0] isetSafe;
  logic [31:0] ratioW;
  logic [31:0] expW;
  logic [19:0] expD;
  assign isetSafe = (isetQ == 16'h0) ? 16'h1 : isetQ;
  assign ratioW = 32'(maxW) * 32'(ocp_pkg::PCT) / 32'(isetSafe);
  // The inverse curve is a plain 1/(M-1) shape; larger currents act faster.
  assign expW = (!ctrlQ[ocp_pkg::CTRL_IDMT]) ? 32'(tdelQ) :
                (ratioW <= 32'(ocp_pkg::PCT)) ? 32'(tdelQ) :
                32'(tdelQ) * 32'(ocp_pkg::PCT) / (ratioW - 32'(ocp_pkg::PCT));
  // Trip test and remaining time use this cycle's figure, so the first count is not stale.
  assign expD = (expW > 32'hfffff) ? 20'hfffff : expW[19:0];
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      ratioQ <= 16'h0;
      expQ <= 20'h0;
    end
    else if (tickQ)
    begin
      ratioQ <= (ratioW > 32'hffff) ? 16'hffff : ratioW[15:0];
      expQ <= expD;
    end
  // ----------------------------------------------------------------
  // Stage state machine
  // ----------------------------------------------------------------
  ocp_pkg::ocp_state_type stQ;
  ocp_pkg::ocp_state_type stD;
  logic [19:0] elapQ;
  logic [19:0] relQ;
  always_comb
  begin
    stD = stQ;
    if (!modeOn)
      stD = ocp_pkg::ST_IDLE;
    else
      case (stQ)
        ocp_pkg::ST_IDLE:
          if (pickAnyD)
            stD = blkNow ? ocp_pkg::ST_BLOCKED : ocp_pkg::ST_START;
        ocp_pkg::ST_START:
          if (!pickAnyD)
            stD = ocp_pkg::ST_IDLE;
          else if (blkNow)
            stD = ocp_pkg::ST_BLOCKED;
          else if (elapQ + 20'h1 >= expD)
            stD = ocp_pkg::ST_TRIP;
        ocp_pkg::ST_TRIP:
          if (!pickAnyD)
            stD = ocp_pkg::ST_IDLE;
          else if (blkNow)
            stD = ocp_pkg::ST_BLOCKED;
        ocp_pkg::ST_BLOCKED:
          if (!pickAnyD || !blkNow)
            stD = ocp_pkg::ST_IDLE;
        default: stD = ocp_pkg::ST_IDLE;
      endcase
  end
  // Blocking is looked at only on the tick, at the head of each cycle.
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      stQ <= ocp_pkg::ST_IDLE;
    else if (tickQ)
      stQ <= stD;
  // Elapsed time survives a drop for the release time, then clears.
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      elapQ <= 20'h0;
      relQ <= 20'h0;
    end
    else if (tickQ)
    begin
      if (stD == ocp_pkg::ST_START)
      begin
        elapQ <= elapQ + 20'h1;
        relQ <= 20'h0;
      end
      else if (stD == ocp_pkg::ST_TRIP)
        relQ <= 20'h0;
      else if (relQ < trelQ)
        relQ <= relQ + 20'h1;
      else
        elapQ <= 20'h0;
    end
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      remQ <= 20'h0;
    else if (tickQ)
      remQ <= (stD == ocp_pkg::ST_START && expD > elapQ + 20'h1) ?
              expD - elapQ - 20'h1 : 20'h0;
  // ----------------------------------------------------------------
  // Outputs, codes and block event
  // ----------------------------------------------------------------
  logic [3:0] phBase;
  always_comb
    case (pickD)
      3'b001: phBase = ocp_pkg::PH_SINGLE;
      3'b010: phBase = ocp_pkg::PH_SINGLE + 4'h1;
      3'b100: phBase = ocp_pkg::PH_SINGLE + 4'h2;
      3'b011: phBase = ocp_pkg::PH_AB;
      3'b110: phBase = ocp_pkg::PH_BC;
      3'b101: phBase = ocp_pkg::PH_CA;
      3'b111: phBase = ocp_pkg::PH_ABC;
      default: phBase = 4'h0;
    endcase
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      stageOut <= '0;
      condQ <= ocp_pkg::COND_NORMAL;
      phCodeQ <= 4'h0;
    end
    else if (tickQ)
    begin
      stageOut.start <= stD == ocp_pkg::ST_START;
      stageOut.trip <= stD == ocp_pkg::ST_TRIP;
      stageOut.blocked <= stD == ocp_pkg::ST_BLOCKED;
      case (stD)
        ocp_pkg::ST_START:
        begin
          condQ <= ocp_pkg::COND_START;
          phCodeQ <= phBase;
        end
        ocp_pkg::ST_TRIP:
        begin
          condQ <= ocp_pkg::COND_TRIP;
          phCodeQ <= phBase + ((phBase < ocp_pkg::PH_AB) ? ocp_pkg::PH_TRIP1 : ocp_pkg::PH_TRIP2);
        end
        ocp_pkg::ST_BLOCKED:
        begin
          condQ <= ocp_pkg::COND_BLOCKED;
          phCodeQ <= 4'h0;
        end
        default:
        begin
          condQ <= ocp_pkg::COND_NORMAL;
          phCodeQ <= 4'h0;
        end
      endcase
    end
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      blockEvt <= '0;
      hmiNote <= 1'b0;
    end
    else
    begin
      blockEvt.valid <= tickQ && stD == ocp_pkg::ST_BLOCKED && stQ != ocp_pkg::ST_BLOCKED;
      hmiNote <= tickQ && stD == ocp_pkg::ST_BLOCKED && stQ != ocp_pkg::ST_BLOCKED;
      if (tickQ && stD == ocp_pkg::ST_BLOCKED && stQ != ocp_pkg::ST_BLOCKED)
      begin
        blockEvt.stamp <= stampQ;
        blockEvt.fault <= pickD;
        blockEvt.cur <= magW;
      end
    end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pick_clear;
    tickQ && pickAnyD && !blkNow && modeOn;
  endsequence
  sequence s_pick_blocked;
    tickQ && pickAnyD && blkNow && modeOn;
  endsequence
  a_start_no_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_pick_clear ##0 (stQ == ocp_pkg::ST_IDLE) |=> stageOut.start && !stageOut.blocked)
    else $error("start missing after clear pick-up");
  a_blocked_instead: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_pick_blocked ##0 (stQ == ocp_pkg::ST_IDLE) |=> stageOut.blocked && !stageOut.start)
    else $error("blocked missing after blocked pick-up");
  a_start_dropped: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tickQ && stQ == ocp_pkg::ST_START && blkNow) |=> !stageOut.start)
    else $error("start kept under blocking");
  a_cycle_sync: assert property (@(posedge ref_clk) disable iff (!nrst)
    !tickQ |=> $stable(stageOut) && $stable(condQ) && $stable(pickQ))
    else $error("outputs moved off the cycle tick");
  a_pick_over: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tickQ && modeOn && magW[0] > isetQ) |=> pickQ[0])
    else $error("pick-up missing above threshold");
  a_pick_hyst: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tickQ && modeOn && pickQ[0] &&
     32'(magW[0]) * 32'(ocp_pkg::PCT) >= 32'(isetQ) * 32'(ocp_pkg::HYST_PCT)) |=> pickQ[0])
    else $error("pick-up released inside hysteresis");
  a_block_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(stageOut.blocked) |-> blockEvt.valid && hmiNote ##1 !blockEvt.valid)
    else $error("block event not one pulse");
  a_cond_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    stageOut.trip |-> condQ == ocp_pkg::COND_TRIP && !stageOut.start)
    else $error("condition code disagrees with trip");
  a_remain_down: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tickQ && stQ == ocp_pkg::ST_START && stD == ocp_pkg::ST_START && remQ != 20'h0)
    |=> remQ < $past(remQ) || remQ == 20'h0 || $changed(expQ))
    else $error("remaining time not counting down");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");
endmodule : ocp_stage

/* File: tb/ocp_far_side.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Far-side blocking matrix
// ----------------------------------------------------------------
module ocp_far_side (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic blockReq,
  output logic blockIn
);
  // The matrix adds one clock of lag; with the stage's synchroniser and filter a request reaches the blocking level five clocks later.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      blockIn <= 1'b0;
    end
    else
    begin
      blockIn <= blockReq;
    end
  end
endmodule : ocp_far_side

/* File: tb/ocp_stage_tb.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Stage bench
// ----------------------------------------------------------------
module ocp_stage_tb;
  localparam int unsigned TICK = 20;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ocp_pkg::ocp_mag_type [2:0] mag;
  logic [2:0][15:0] harm2;
  logic [2:0][15:0] fund;
  logic blockReq;
  logic blockIn;
  ocp_pkg::ocp_out_type stageOut;
  ocp_pkg::ocp_evt_type blockEvt;
  logic hmiNote;
  logic cycleTick;
  logic [2:0] watched;
  logic [2:0] outPrev = 3'h0;
  logic tickPrev = 1'b0;
  logic [31:0] rdQ[$];
  logic [31:0] mskQ[$];
  logic [2:0] outQ[$];
  logic [15:0] evQ[$];
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  int tickCount = 0;
  int ph = 0;
  int magSel = 1;
  always #2.5 ref_clk = ~ref_clk;
  // Start drops when trip rises here, so the start bit is folded with trip to stay neutral.
  assign watched = {stageOut.start | stageOut.trip, stageOut.trip, stageOut.blocked};
  ocp_stage #(.CYCLE_CLKS(TICK)) DUT (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .measured_magnitude(mag), .harm2In(harm2),
    .fundIn(fund), .blockIn(blockIn), .stageOut(stageOut), .blockEvt(blockEvt),
    .hmiNote(hmiNote), .cycleTick(cycleTick));
  ocp_far_side farSide (.ref_clk(ref_clk), .nrst(nrst), .blockReq(blockReq),
    .blockIn(blockIn));
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
    checksDone++;
    if (s !== e)
    begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    checksDone++;
    if (s !== e)
    begin
      failCount++;
      $display("BAD %s expected %b seen %b", nm, e, s);
    end
  endtask : cmp_bit
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : completeRun
  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      completeRun();
    end
    if (nrst === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      cmp_word("readdata", rdQ.pop_front(), avs_readdata & mskQ.pop_front());
    end
    if (nrst === 1'b1 && watched !== outPrev)
    begin
      cmp_bit("tick", 1'b1, tickPrev);
      cmp_word("stage", {29'h0, outQ.pop_front()}, {29'h0, watched});
    end
    if (nrst === 1'b1 && blockEvt.valid === 1'b1)
    begin
      cmp_bit("note", 1'b1, hmiNote);
      cmp_word("event", {16'h0, evQ.pop_front()}, {16'h0, blockEvt.cur[ph]});
      cmp_word("fault", 32'(1 << ph), {29'h0, blockEvt.fault});
      cmp_word("stamp", 32'((tickCount - 1) * ocp_pkg::STAMP_MS), blockEvt.stamp);
    end
    if (cycleTick === 1'b1)
      tickCount++;
    outPrev <= watched;
    tickPrev <= cycleTick;
  end
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus_req(input logic [5:0] a, input logic [31:0] d, input logic wr);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_req
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hffffffff);
    rdQ.push_back(e);
    mskQ.push_back(m);
    bus_req(a, 32'h0, 1'b0);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_req(a, d, 1'b1);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk iff cycleTick === 1'b1);
  endtask : tick
  task automatic fault(input logic [15:0] v);
    ocp_pkg::ocp_mag_type [2:0] m;
    // Idle phases and unused fields carry noise below the release level.
    for (int p = 0; p < 3; p++)
      m[p] = {16'($urandom % 32'h70), 16'($urandom % 32'h70), 16'($urandom % 32'h70)};
    case (magSel)
      1: m[ph].rms = v;
      2: m[ph].trms = v;
      default: m[ph].pp = v;
    endcase
    mag <= m;
  endtask : fault
  task automatic till(input logic [2:0] v, input int n);
    repeat (n)
    begin
      tick(1);
      @(posedge ref_clk);
      if (watched === v)
        break;
    end
  endtask : till
  task automatic hit(input logic [2:0] v, input logic [15:0] c);
    outQ.push_back(v);
    if (v == 3'h1)
      evQ.push_back(c);
    fault(c);
    till(v, 3);
    outQ.push_back(3'h0);
    fault(16'h0000);
    till(3'h0, 3);
  endtask : hit
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(60961));
    ph = $urandom % 3;
    avs_address <= 6'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    blockReq <= 1'b0;
    harm2 <= '0;
    fund <= {16'($urandom), 16'($urandom), 16'($urandom)};
    fault(16'h0000);
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ocp_pkg::OFF_CTRL, 32'h28);
    rd(ocp_pkg::OFF_ISET, 32'h78);
    rd(ocp_pkg::OFF_HLIM, 32'h01);
    rd(ocp_pkg::OFF_TDEL, 32'h14);
    rd(ocp_pkg::OFF_STAT, 32'h100, 32'h7ff);
    rd(6'h24, 32'h0);
    wr(ocp_pkg::OFF_TDEL, 32'h03);
    wr(ocp_pkg::OFF_CTRL, 32'h128);
    outQ.push_back(3'h4);
    fault(16'h0096);
    till(3'h4, 4);
    rd(ocp_pkg::OFF_STAT, 32'h101 | 32'((ph + 1) << 4), 32'h7ff);
    rd(ocp_pkg::OFF_EXPT, 32'h0c);
    rd(ocp_pkg::OFF_REMT, 32'h0b);
    rd(ocp_pkg::OFF_RATIO, 32'h7d);
    till(3'h4, 1);
    rd(ocp_pkg::OFF_REMT, 32'h0a);
    outQ.push_back(3'h6);
    till(3'h6, 12);
    rd(ocp_pkg::OFF_STAT, 32'h102 | 32'((ph + 4) << 4), 32'h7ff);
    wr(ocp_pkg::OFF_CTRL, 32'h28);
    tick(1);
    rd(ocp_pkg::OFF_EXPT, 32'h03);
    fault(16'h0075);
    tick(3);
    outQ.push_back(3'h0);
    fault(16'h0074);
    till(3'h0, 3);
    wr(ocp_pkg::OFF_TDEL, 32'h14);
    fault(16'h0078);
    tick(3);
    outQ.push_back(3'h4);
    fault(16'h0079);
    till(3'h4, 4);
    blockReq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    blockReq <= 1'b0;
    tick(2);
    outQ.push_back(3'h1);
    evQ.push_back(16'h0079);
    blockReq <= 1'b1;
    till(3'h1, 3);
    rd(ocp_pkg::OFF_STAT, 32'h103, 32'h7ff);
    outQ.push_back(3'h0);
    fault(16'h0000);
    till(3'h0, 3);
    hit(3'h1, 16'h0096);
    wr(ocp_pkg::OFF_CTRL, 32'h2a);
    hit(3'h4, 16'h0096);
    blockReq <= 1'b0;
    wr(ocp_pkg::OFF_CTRL, 32'h2e);
    hit(3'h1, 16'h0096);
    wr(ocp_pkg::OFF_CTRL, 32'h29);
    wr(ocp_pkg::OFF_HLIM, 32'h3e8);
    fund[ph] <= 16'h03e8;
    harm2[ph] <= 16'h0064;
    hit(3'h1, 16'h0096);
    harm2[ph] <= 16'h0063;
    hit(3'h4, 16'h0096);
    for (int s = 1; s <= 3; s++)
    begin
      magSel = s;
      ph = $urandom % 3;
      wr(ocp_pkg::OFF_CTRL, 32'h20 | 32'(s << 3));
      hit(3'h4, 16'(130 + s));
    end
    for (int m = 1; m <= 5; m++)
    begin
      wr(ocp_pkg::OFF_CTRL, 32'(m << 5) | 32'(magSel << 3));
      rd(ocp_pkg::OFF_STAT, 32'(m << 8), 32'h700);
      if (m == 2)
        hit(3'h1, 16'h008c);
    end
    completeRun();
  end
endmodule : ocp_stage_tb
